/* File: scr_pkg.sv */
/*
 * Constants and types for the control register bank and its bus target.
 * Assumes one clock, clk_sys, at 25 MHz.
 */
`default_nettype none

package scr_pkg;

   // ****************************************
   // Register offsets and fields
   // ****************************************
   localparam logic [7:0] ADDR_DEV_ID = 8'h00;
   localparam logic [7:0] ADDR_RESET = 8'h01;
   localparam logic [7:0] ADDR_GEN_CFG = 8'h03;

   localparam int ID_SEL_BIT = 0;
   localparam int RST_LOGIC_BIT = 0;
   localparam int RST_FULL_BIT = 1;
   localparam int CFG_CRC_BIT = 7;
   localparam int CFG_AUTO_ACK_BIT = 5;
   localparam int CFG_FILTER_BIT = 4;
   localparam int CFG_PASS_BIT = 3;
   localparam int CFG_PCLK_AUTO_BIT = 1;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] GEN_CFG_RESET = 8'hd2;
   localparam logic [7:0] RESET_REG_RESET = 8'h00;
   localparam logic ID_SEL_RESET = 1'b0;

   // ****************************************
   // Strap addresses
   // ****************************************
   localparam int STRAP_W = 3;
   localparam logic [6:0] STRAP_BASE_ADDR = 7'h0c;
   localparam logic [6:0] PORT1_ADDR_OFFSET = 7'h01;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int SOFT_RESET_NS = 320;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SOFT_CNT_W = 8;

   // ****************************************
   // Serial target states
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_REG = 3'b010,
      ST_WDAT = 3'b011,
      ST_ACK = 3'b100,
      ST_RDAT = 3'b101,
      ST_MACK = 3'b110,
      ST_RNXT = 3'b111
   } scr_i2c_st_t;

endpackage

`default_nettype wire

/* File: scr_regbus_if.sv */
/*
 * Register access path between the serial target and the register bank.
 * Assumes both ends run on clk_sys.
 */
`default_nettype none

interface scr_regbus_if;
   logic wr_stb;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] ptr;
   logic [7:0] rdata;
   logic [6:0] dev_addr0;
   logic [6:0] dev_addr1;
   logic addr1_en;

   modport tgt (
      output wr_stb, wr_addr, wr_data, ptr,
      input rdata, dev_addr0, dev_addr1, addr1_en
   );
   modport bank (
      input wr_stb, wr_addr, wr_data, ptr,
      output rdata, dev_addr0, dev_addr1, addr1_en
   );
endinterface

`default_nettype wire

/* File: scr_i2c_target.sv */
/*
 * Serial control bus target: framing, address match, pointer, register access.
 * Assumes open-drain SCL/SDA pins resolved outside; SCL is never stretched.
 */
`default_nettype none

module scr_i2c_target
   import scr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   scr_regbus_if.tgt bus
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] scl_sh_q;
   logic [2:0] sda_sh_q;
   logic scl_f_q;
   logic sda_f_q;
   logic scl_p_q;
   logic sda_p_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         scl_sh_q <= 3'h7;
         sda_sh_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_sh_q <= {scl_sh_q[1:0], scl_in};
         sda_sh_q <= {sda_sh_q[1:0], sda_in};
         if (scl_sh_q[1] == scl_sh_q[2]) begin
            scl_f_q <= scl_sh_q[2];
         end
         if (sda_sh_q[1] == sda_sh_q[2]) begin
            sda_f_q <= sda_sh_q[2];
         end
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end

   logic rise;
   logic fall;
   logic start;
   logic stop;
   assign rise = scl_f_q && !scl_p_q;
   assign fall = !scl_f_q && scl_p_q;
   assign start = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
   assign stop = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;

   // ****************************************
   // Transfer state machine
   // ****************************************
   scr_i2c_st_t st_q;
   scr_i2c_st_t ph_q;
   logic [3:0] bcnt_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic rw_q;
   logic [7:0] ptr_q;
   logic wr_stb_q;
   logic [7:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic sda_oe_q;
   logic sda_out_q;
   logic match;

   // Port 1 answers only while its address is enabled
   assign match = (sh_q[7:1] == bus.dev_addr0) ||
                  (bus.addr1_en && (sh_q[7:1] == bus.dev_addr1));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_q <= ST_IDLE;
         ph_q <= ST_IDLE;
         bcnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         ptr_q <= 8'h00;
         wr_stb_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         sda_oe_q <= 1'b0;
         sda_out_q <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         sda_out_q <= 1'b0;
         if (start) begin
            st_q <= ST_ADDR;
            bcnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (stop) begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            case (st_q)
               ST_ADDR, ST_REG, ST_WDAT: begin
                  if (rise) begin
                     sh_q <= {sh_q[6:0], sda_f_q};
                     bcnt_q <= bcnt_q + 4'h1;
                  end else if (fall && bcnt_q == 4'h8) begin
                     bcnt_q <= 4'h0;
                     ph_q <= st_q;
                     if (st_q == ST_ADDR && !match) begin
                        st_q <= ST_IDLE;
                     end else begin
                        sda_oe_q <= 1'b1;
                        st_q <= ST_ACK;
                     end
                     if (st_q == ST_ADDR) begin
                        rw_q <= sh_q[0];
                     end
                     if (st_q == ST_REG) begin
                        ptr_q <= sh_q;
                     end
                     if (st_q == ST_WDAT) begin
                        wr_stb_q <= 1'b1;
                        wr_addr_q <= ptr_q;
                        wr_data_q <= sh_q;
                        ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
               ST_ACK: begin
                  if (fall) begin
                     if (ph_q == ST_ADDR && rw_q) begin
                        tx_q <= bus.rdata;
                        sda_oe_q <= !bus.rdata[7];
                        st_q <= ST_RDAT;
                     end else begin
                        sda_oe_q <= 1'b0;
                        st_q <= (ph_q == ST_ADDR) ? ST_REG : ST_WDAT;
                     end
                  end
               end
               ST_RDAT: begin
                  if (fall) begin
                     bcnt_q <= bcnt_q + 4'h1;
                     if (bcnt_q == 4'h7) begin
                        sda_oe_q <= 1'b0;
                        st_q <= ST_MACK;
                     end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= !tx_q[6];
                     end
                  end
               end
               ST_MACK: begin
                  if (rise) begin
                     if (sda_f_q) begin
                        st_q <= ST_IDLE;
                     end else begin
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= ST_RNXT;
                     end
                  end
               end
               ST_RNXT: begin
                  if (fall) begin
                     tx_q <= bus.rdata;
                     sda_oe_q <= !bus.rdata[7];
                     bcnt_q <= 4'h0;
                     st_q <= ST_RDAT;
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign bus.wr_stb = wr_stb_q;
   assign bus.wr_addr = wr_addr_q;
   assign bus.wr_data = wr_data_q;
   assign bus.ptr = ptr_q;
   assign sda_oe = sda_oe_q;
   assign sda_out = sda_out_q;

endmodule

`default_nettype wire

/* File: scr_serializer_regs.sv */
/*
 * Serializer control register bank: bus address selection, soft resets,
 * general configuration, sync/enable pulse filter, remote write handling.
 * Assumes video inputs and remote-side status come from clk_sys logic.
 */
`default_nettype none

// How it works
// - Port 0 bus address field loads from the strap after reset.
// - Port 1 address field loads strap address plus one.
// - Second-port select steers address field reads and writes to port 1.
// - Address bit 0 picks strap address or programmed address.
// - Reset bit 1 resets logic and all registers, then clears itself.
// - Reset bit 0 resets logic, keeps registers, then clears itself.
// - Logic reset reloads strapped registers from the strap pin.
// - Logic reset pulses a restore for outer default registers.
// - Config bit 7 enables the back-channel CRC checker, default on.
// - Config bit 5 acknowledges remote writes at once, default off.
// - With auto acknowledge, remote not-acknowledge is hidden from the master.
// - Config bit 4 rejects enable and sync pulses under two clocks.
// - Config bit 3 forwards alias-matching transactions remotely, default off.
// - Auto acknowledge and pass-through fields follow second-port select.
// - Strap picks one of eight addresses, 0x0c to 0x1a step two.
module scr_serializer_regs
#(
   parameter int SOFT_RESET_CYCLES = scr_pkg::SOFT_RESET_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [scr_pkg::STRAP_W-1:0] strap_address_pin,
   input wire logic second_port_address_enable,
   input wire logic second_port_select,
   input wire logic display_enable,
   input wire logic horizontal_sync,
   input wire logic vertical_sync,
   output logic display_enable_filt,
   output logic horizontal_sync_filt,
   output logic vertical_sync_filt,
   input wire logic remote_nack,
   input wire logic remote_port,
   input wire logic alias_match,
   input wire logic alias_port,
   output logic local_nack,
   output logic forward_remote,
   output logic crc_check_enable,
   output logic pclk_auto_switch,
   output logic [1:0] write_auto_ack,
   output logic [1:0] pass_through,
   output logic [6:0] device_address0,
   output logic [6:0] device_address1,
   output logic core_reset,
   output logic restore_defaults
);

   import scr_pkg::*;

   scr_regbus_if bus ();

   scr_i2c_target u_tgt (
      .clk_sys(clk_sys),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .bus(bus.tgt)
   );

   // ****************************************
   // Strap capture
   // ****************************************
   // The strap is static, so a bus-wide synchroniser is safe once settled
   logic [STRAP_W-1:0] strap_s1_q;
   logic [STRAP_W-1:0] strap_s2_q;
   logic [STRAP_W-1:0] strap_s3_q;
   logic [STRAP_W-1:0] strap_idx_q;
   logic [1:0] strap_wait_q;
   logic strap_take;

   function automatic logic [6:0] strap_addr(input logic [STRAP_W-1:0] idx);
      strap_addr = STRAP_BASE_ADDR + {3'b000, idx, 1'b0};
   endfunction

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         strap_s1_q <= '0;
         strap_s2_q <= '0;
         strap_s3_q <= '0;
      end else begin
         strap_s1_q <= strap_address_pin;
         strap_s2_q <= strap_s1_q;
         strap_s3_q <= strap_s2_q;
      end
   end

   assign strap_take = (strap_wait_q == 2'h1) && (strap_s2_q == strap_s3_q);

   // ****************************************
   // Soft reset sequencing
   // ****************************************
   logic wr_reset;
   logic full_go;
   logic logic_go;
   logic [SOFT_CNT_W-1:0] seq_cnt_q;
   logic [1:0] rst_bits_q;
   logic core_reset_q;
   logic restore_q;

   assign wr_reset = bus.wr_stb && (bus.wr_addr == ADDR_RESET);
   assign full_go = wr_reset && bus.wr_data[RST_FULL_BIT];
   assign logic_go = wr_reset && bus.wr_data[RST_LOGIC_BIT] && !full_go;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         seq_cnt_q <= '0;
         rst_bits_q <= RESET_REG_RESET[1:0];
         core_reset_q <= 1'b0;
         restore_q <= 1'b0;
      end else begin
         restore_q <= full_go || logic_go;
         core_reset_q <= full_go || logic_go || (seq_cnt_q > SOFT_CNT_W'(1));
         if (full_go || logic_go) begin
            seq_cnt_q <= SOFT_CNT_W'(SOFT_RESET_CYCLES);
            rst_bits_q <= {full_go, logic_go};
         end else if (seq_cnt_q != '0) begin
            seq_cnt_q <= seq_cnt_q - SOFT_CNT_W'(1);
            if (seq_cnt_q == SOFT_CNT_W'(1)) begin
               rst_bits_q <= 2'b00;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         strap_wait_q <= 2'h3;
         strap_idx_q <= '0;
      end else begin
         if (full_go || logic_go) begin
            strap_wait_q <= 2'h3;
         end else if (strap_take) begin
            strap_wait_q <= 2'h0;
            strap_idx_q <= strap_s3_q;
         end else if (strap_wait_q > 2'h1) begin
            strap_wait_q <= strap_wait_q - 2'h1;
         end
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   logic wr_id;
   logic wr_cfg;
   logic sel;
   logic [1:0][6:0] id_q;
   logic id_sel_q;
   logic crc_q;
   logic filt_q;
   logic pclk_q;
   logic [1:0] ack_q;
   logic [1:0] pass_q;

   assign sel = second_port_select;
   assign wr_id = bus.wr_stb && (bus.wr_addr == ADDR_DEV_ID);
   assign wr_cfg = bus.wr_stb && (bus.wr_addr == ADDR_GEN_CFG);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         id_q <= {STRAP_BASE_ADDR + PORT1_ADDR_OFFSET, STRAP_BASE_ADDR};
         id_sel_q <= ID_SEL_RESET;
         crc_q <= GEN_CFG_RESET[CFG_CRC_BIT];
         filt_q <= GEN_CFG_RESET[CFG_FILTER_BIT];
         pclk_q <= GEN_CFG_RESET[CFG_PCLK_AUTO_BIT];
         ack_q <= {2{GEN_CFG_RESET[CFG_AUTO_ACK_BIT]}};
         pass_q <= {2{GEN_CFG_RESET[CFG_PASS_BIT]}};
      end else if (full_go) begin
         // Whole register file back to defaults; strap fields follow on capture
         id_sel_q <= ID_SEL_RESET;
         crc_q <= GEN_CFG_RESET[CFG_CRC_BIT];
         filt_q <= GEN_CFG_RESET[CFG_FILTER_BIT];
         pclk_q <= GEN_CFG_RESET[CFG_PCLK_AUTO_BIT];
         ack_q <= {2{GEN_CFG_RESET[CFG_AUTO_ACK_BIT]}};
         pass_q <= {2{GEN_CFG_RESET[CFG_PASS_BIT]}};
      end else begin
         if (strap_take) begin
            id_q[0] <= strap_addr(strap_s3_q);
            id_q[1] <= strap_addr(strap_s3_q) + PORT1_ADDR_OFFSET;
         end
         if (wr_id) begin
            id_q[sel] <= bus.wr_data[7:1];
            id_sel_q <= bus.wr_data[ID_SEL_BIT];
         end
         if (wr_cfg) begin
            crc_q <= bus.wr_data[CFG_CRC_BIT];
            filt_q <= bus.wr_data[CFG_FILTER_BIT];
            pclk_q <= bus.wr_data[CFG_PCLK_AUTO_BIT];
            ack_q[sel] <= bus.wr_data[CFG_AUTO_ACK_BIT];
            pass_q[sel] <= bus.wr_data[CFG_PASS_BIT];
         end
      end
   end

   // Address in use per port, registered so the target sees a steady value
   logic [1:0][6:0] dev_addr_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dev_addr_q <= {STRAP_BASE_ADDR + PORT1_ADDR_OFFSET, STRAP_BASE_ADDR};
      end else begin
         dev_addr_q[0] <= id_sel_q ? id_q[0] : strap_addr(strap_idx_q);
         dev_addr_q[1] <= id_sel_q ? id_q[1] :
                          strap_addr(strap_idx_q) + PORT1_ADDR_OFFSET;
      end
   end

   assign bus.dev_addr0 = dev_addr_q[0];
   assign bus.dev_addr1 = dev_addr_q[1];
   assign bus.addr1_en = second_port_address_enable;

   // Bit 6 reads its default one, bits 2 and 0 read zero
   always_comb begin
      case (bus.ptr)
         ADDR_DEV_ID: bus.rdata = {id_q[sel], id_sel_q};
         ADDR_RESET: bus.rdata = {6'h00, rst_bits_q};
         ADDR_GEN_CFG: bus.rdata = {crc_q, GEN_CFG_RESET[6], ack_q[sel], filt_q,
                                    pass_q[sel], 1'b0, pclk_q, 1'b0};
         default: bus.rdata = 8'h00;
      endcase
   end

   // ****************************************
   // Remote write handling
   // ****************************************
   logic local_nack_q;
   logic forward_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         local_nack_q <= 1'b0;
         forward_q <= 1'b0;
      end else begin
         local_nack_q <= remote_nack && !ack_q[remote_port];
         forward_q <= alias_match && pass_q[alias_port];
      end
   end

   // ****************************************
   // Enable and sync pulse filter
   // ****************************************
   // Costs one cycle of latency per edge even for long pulses
   logic [2:0] vid_in;
   logic [2:0] vid_h_q;
   logic [2:0] vid_o_q;

   assign vid_in = {vertical_sync, horizontal_sync, display_enable};

   for (genvar i = 0; i < 3; i++) begin : g_filt
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            vid_h_q[i] <= 1'b0;
            vid_o_q[i] <= 1'b0;
         end else begin
            vid_h_q[i] <= vid_in[i];
            if (!filt_q) begin
               vid_o_q[i] <= vid_in[i];
            end else if (vid_in[i] == vid_h_q[i]) begin
               vid_o_q[i] <= vid_in[i];
            end
         end
      end
   end

   assign display_enable_filt = vid_o_q[0];
   assign horizontal_sync_filt = vid_o_q[1];
   assign vertical_sync_filt = vid_o_q[2];
   assign local_nack = local_nack_q;
   assign forward_remote = forward_q;
   assign crc_check_enable = crc_q;
   assign pclk_auto_switch = pclk_q;
   assign write_auto_ack = ack_q;
   assign pass_through = pass_q;
   assign device_address0 = dev_addr_q[0];
   assign device_address1 = dev_addr_q[1];
   assign core_reset = core_reset_q;
   assign restore_defaults = restore_q;

endmodule

`default_nettype wire

/* File: scr_i2c_host.sv */
/* Serial bus host model: START, STOP, nine-bit slots.
   Assumes SCL and SDA resolved as pulled-up open-drain wires. */
`default_nettype none

module scr_i2c_host (
   input wire logic clk_sys,
   input wire logic sda_in,
   output logic scl_low,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // Bus phases
   // ****************************************
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic start();
      sda_low = 1'b0;
      hold(8);
      scl_low = 1'b0;
      hold(8);
      sda_low = 1'b1;
      hold(8);
      scl_low = 1'b1;
      hold(4);
   endtask

   task automatic stop();
      sda_low = 1'b1;
      hold(4);
      scl_low = 1'b0;
      hold(8);
      sda_low = 1'b0;
      hold(8);
   endtask

   // Eight bits and the acknowledge slot, MSB first; a 1 releases SDA
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_low = !tx[i];
         hold(4);
         scl_low = 1'b0;
         hold(8);
         rx[i] = sda_in;
         scl_low = 1'b1;
         hold(4);
      end
   endtask
endmodule

`default_nettype wire

/* File: scr_serializer_regs_sva.sv */
/* Port assertions for the register bank.
   Assumes a bind to scr_serializer_regs on clk_sys. */
`default_nettype none

module scr_serializer_regs_sva
   import scr_pkg::*;
#(
   parameter int SOFT_RESET_CYCLES = 8
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [scr_pkg::STRAP_W-1:0] strap_address_pin,
   input wire logic display_enable,
   input wire logic horizontal_sync,
   input wire logic display_enable_filt,
   input wire logic horizontal_sync_filt,
   input wire logic remote_nack,
   input wire logic remote_port,
   input wire logic alias_match,
   input wire logic alias_port,
   input wire logic local_nack,
   input wire logic forward_remote,
   input wire logic [1:0] write_auto_ack,
   input wire logic [1:0] pass_through,
   input wire logic [6:0] device_address0,
   input wire logic [6:0] device_address1,
   input wire logic core_reset,
   input wire logic restore_defaults
);
   // ****************************************
   // Soft reset length counter
   // ****************************************
   logic [7:0] run_q;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         run_q <= 8'h00;
      end else begin
         run_q <= core_reset ? run_q + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   AST_NACK_PASS: assert property (remote_nack && !write_auto_ack[remote_port] |=> local_nack)
      else $error("nack lost");
   AST_NACK_HIDE: assert property (remote_nack && write_auto_ack[remote_port] |=> !local_nack)
      else $error("nack leaked");
   AST_NACK_QUIET: assert property (!remote_nack |=> !local_nack)
      else $error("stray nack");
   AST_FORWARD: assert property (1'b1 |=> forward_remote == $past(alias_match && pass_through[alias_port]))
      else $error("bad forward");
   AST_FILT_DE: assert property ($changed(display_enable_filt) |-> display_enable_filt == $past(display_enable))
      else $error("de filter");
   AST_FILT_HS: assert property ($changed(horizontal_sync_filt) |-> horizontal_sync_filt == $past(horizontal_sync))
      else $error("hs filter");
   AST_RESET_LEN: assert property ($fell(core_reset) |-> run_q == SOFT_RESET_CYCLES)
      else $error("reset length");
   AST_RESET_BOUND: assert property (core_reset |-> run_q < SOFT_RESET_CYCLES)
      else $error("reset overrun");
   AST_RESTORE: assert property (restore_defaults |-> $rose(core_reset) ##1 !restore_defaults)
      else $error("restore pulse");
   AST_STRAP0: assert property ($rose(core_reset) |-> ##[1:8]
      device_address0 == STRAP_BASE_ADDR + 7'({strap_address_pin, 1'b0}))
      else $error("port0 strap");
   AST_STRAP1: assert property ($rose(core_reset) |-> ##[1:8]
      device_address1 == STRAP_BASE_ADDR + 7'({strap_address_pin, 1'b1}))
      else $error("port1 strap");
endmodule

`default_nettype wire

/* File: scr_serializer_regs_tb.sv */
/* Bench for the control register bank.
   Assumes the host model drives the bus; wires resolved here. */
`default_nettype none

module scr_serializer_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import scr_pkg::*;

   // ****************************************
   // Harness
   // ****************************************
   // Short soft reset keeps the run brief
   localparam int SRC = 4;
   logic clk_sys, reset, sda_oe, sda_out, scl_low, sda_low, sda, scl, sel, p1_en;
   logic r_nack, r_port, a_match, a_port, local_nack, fwd, crc, pclk, core_reset, restore;
   logic [2:0] strap, vid, vid_f;
   logic [1:0] auto_ack, pass;
   logic [6:0] addr0, addr1, dev_a;
   int bad_count = 0;
   int checked = 0;
   assign scl = !scl_low;
   assign sda = !(sda_low || sda_oe);

   scr_serializer_regs #(.SOFT_RESET_CYCLES(SRC)) uut (
      .clk_sys, .reset, .scl_in(scl), .sda_in(sda), .sda_out,
      .sda_oe, .strap_address_pin(strap), .second_port_address_enable(p1_en),
      .second_port_select(sel), .display_enable(vid[0]), .horizontal_sync(vid[1]),
      .vertical_sync(vid[2]), .display_enable_filt(vid_f[0]),
      .horizontal_sync_filt(vid_f[1]), .vertical_sync_filt(vid_f[2]),
      .remote_nack(r_nack), .remote_port(r_port), .alias_match(a_match),
      .alias_port(a_port), .local_nack, .forward_remote(fwd),
      .crc_check_enable(crc), .pclk_auto_switch(pclk), .write_auto_ack(auto_ack),
      .pass_through(pass), .device_address0(addr0), .device_address1(addr1),
      .core_reset(core_reset), .restore_defaults(restore));
   scr_i2c_host host (.clk_sys(clk_sys), .sda_in(sda), .scl_low(scl_low), .sda_low(sda_low));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic do_reset();
      reset = 1'b1;
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      logic [8:0] a, b, c;
      host.start();
      host.xfer({dev_a, 2'b01}, a);
      host.xfer({off, 1'b1}, b);
      host.xfer({d, 1'b1}, c);
      host.stop();
      chk({7'h0, a[0] | b[0] | c[0]}, 8'h00);
   endtask

   task automatic rd(input logic [7:0] off, input logic [7:0] exp);
      logic [8:0] a, b, c, d;
      host.start();
      host.xfer({dev_a, 2'b01}, a);
      host.xfer({off, 1'b1}, b);
      host.start();
      host.xfer({dev_a, 2'b11}, c);
      host.xfer(9'h1ff, d);
      host.stop();
      chk({7'h0, a[0] | b[0] | c[0]}, 8'h00);
      chk(d[8:1], exp);
   endtask

   task automatic probe(input logic port, input logic [1:0] exp);
      r_nack = 1'b1;
      a_match = 1'b1;
      r_port = port;
      a_port = port;
      @(negedge clk_sys);
      chk({6'h0, local_nack, fwd}, {6'h0, exp});
   endtask

   task automatic pulse(input int n, input logic [2:0] exp);
      logic [2:0] seen = 3'h0;
      vid = 3'h7;
      repeat (n + 4) begin
         @(negedge clk_sys);
         vid = (n > 1) ? vid : 3'h0;
         n--;
         seen = seen | vid_f;
      end
      chk({5'h0, seen}, {5'h0, exp});
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_strap();
      for (int k = 0; k < 8; k++) begin
         strap = 3'(k);
         do_reset();
         chk({1'b0, addr0}, 8'h0c + 8'(2 * k));
         chk({1'b0, addr1}, 8'h0d + 8'(2 * k));
      end
      strap = 3'h3;
      do_reset();
      dev_a = 7'h12;
      rd(8'h00, 8'h24);
      rd(8'h01, 8'h00);
      rd(8'h03, 8'hd2);
      chk({7'h0, crc}, 8'h01);
   endtask

   task automatic t_cfg();
      wr(8'h03, 8'h28);
      chk({2'h0, crc, pclk, auto_ack, pass}, 8'h05);
      probe(1'b0, 2'b01);
      probe(1'b1, 2'b10);
      pulse(1, 3'h7);
      sel = 1'b1;
      wr(8'h03, 8'h20);
      rd(8'h03, 8'h60);
      probe(1'b1, 2'b00);
      sel = 1'b0;
      rd(8'h03, 8'h68);
   endtask

   task automatic t_addr();
      wr(8'h00, 8'h55);
      dev_a = 7'h2a;
      rd(8'h00, 8'h55);
      sel = 1'b1;
      wr(8'h00, 8'h67);
      dev_a = 7'h33;
      rd(8'h00, 8'h67);
      sel = 1'b0;
      chk({1'b0, addr0}, 8'h2a);
   endtask

   task automatic t_soft();
      wr(8'h01, 8'h01);
      dev_a = 7'h12;
      rd(8'h00, 8'h25);
      rd(8'h01, 8'h00);
      rd(8'h03, 8'h68);
      wr(8'h01, 8'h02);
      rd(8'h03, 8'hd2);
      rd(8'h00, 8'h24);
      chk({4'h0, auto_ack, pass}, 8'h00);
      pulse(1, 3'h0);
      pulse(2, 3'h7);
   endtask

   task automatic t_refuse();
      logic [8:0] a;
      rd(8'h02, 8'h00);
      host.start();
      host.xfer({7'h7e, 2'b01}, a);
      host.stop();
      chk({7'h0, a[0]}, 8'h01);
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      #1500000;
      bad_count++;
      end_of_test();
   end

   initial begin
      {sel, r_nack, r_port, a_match, a_port} = 5'h0;
      p1_en = 1'b1;
      strap = 3'h3;
      vid = 3'h0;
      dev_a = 7'h12;
      t_strap();
      t_cfg();
      t_addr();
      t_soft();
      t_refuse();
      end_of_test();
   end
endmodule

bind scr_serializer_regs scr_serializer_regs_sva #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) chk_i (
   .clk_sys, .reset, .strap_address_pin, .display_enable, .horizontal_sync,
   .display_enable_filt, .horizontal_sync_filt, .remote_nack, .remote_port, .alias_match,
   .alias_port, .local_nack, .forward_remote, .write_auto_ack, .pass_through,
   .device_address0, .device_address1, .core_reset, .restore_defaults);

`default_nettype wire
